// ==== src/pes_pkg.sv ====
package pes_pkg;
	// ****************************************************************
	// event selection codes
	// ****************************************************************
	localparam logic [7:0] EVT_DTLB        = 8'h08;
	localparam logic [7:0] EVT_DISAMBIG    = 8'h09;
	localparam logic [7:0] EVT_PAGE_WALK   = 8'h0C;
	localparam logic [7:0] EVT_FP_COMP     = 8'h10;
	localparam logic [7:0] EVT_FP_HELP     = 8'h11;
	localparam logic [7:0] EVT_PRODUCT     = 8'h12;
	localparam logic [7:0] UM_STORE_MISS   = 8'h08;
	localparam logic [7:0] UM_DIS_RESET    = 8'h01;
	localparam logic [7:0] UM_DIS_SUCCESS  = 8'h02;
	localparam logic [7:0] UM_WALK_COUNT   = 8'h01;
	localparam logic [7:0] UM_WALK_CYCLES  = 8'h02;
	localparam logic [7:0] UM_NONE         = 8'h00;
	// ****************************************************************
	// counter layout
	// ****************************************************************
	localparam int         CNT_WIDTH       = 40;
	localparam logic [0:0] COUNTER_ZERO    = 1'b0;
	localparam logic [0:0] COUNTER_ONE     = 1'b1;
	localparam int         HELP_SRC_COUNT  = 5;
	localparam int         SEL_WIDTH       = 4;

	typedef enum logic [3:0] {
		SRC_NONE,
		SRC_STORE_MISS,
		SRC_DIS_RESET,
		SRC_DIS_SUCCESS,
		SRC_WALK_START,
		SRC_WALK_BUSY,
		SRC_FP_COMP,
		SRC_FP_HELP,
		SRC_PRODUCT
	} pes_src_t;
endpackage : pes_pkg

// ==== src/pes_fp_help.sv ====
`timescale 1ns/1ps
// assist detector: folds the SIMD and x87 assist causes into one pulse
module pes_fp_help
	import pes_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic simdOpValid,
	input  wire logic simdDenormalIn,
	input  wire logic simdUnderflowOut,
	input  wire logic denormal_input_zeroing_flag,
	input  wire logic underflow_result_flush_flag,
	input  wire logic x87OpValid,
	input  wire logic x87NanOrDenormLoad,
	input  wire logic x87DivByZero,
	input  wire logic x87UnderflowOut,
	output logic      float_microcode_help_event
);
	import pes_pkg::*;

	logic [HELP_SRC_COUNT-1:0] cause;
	logic                      helpReg;
	logic                      helpNext;

	always_comb begin
		cause[0] = simdOpValid & simdDenormalIn & ~denormal_input_zeroing_flag;
		cause[1] = simdOpValid & simdUnderflowOut & ~underflow_result_flush_flag;
		cause[2] = x87OpValid & x87NanOrDenormLoad;
		cause[3] = x87OpValid & x87DivByZero;
		cause[4] = x87OpValid & x87UnderflowOut;
		helpNext = |cause;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			helpReg <= 1'b0;
		end else begin
			helpReg <= helpNext;
		end
	end

	assign float_microcode_help_event = helpReg;

	chk_help_simd_denorm: assert property (@(posedge clk) disable iff (!rst_n)
		simdOpValid && simdDenormalIn && !denormal_input_zeroing_flag |=> float_microcode_help_event)
		else $error("simd denormal assist not flagged");
	chk_help_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!simdOpValid && !x87OpValid |=> !float_microcode_help_event)
		else $error("assist flagged with no operation");
endmodule : pes_fp_help

// ==== src/pes_selector.sv ====
`timescale 1ns/1ps
// Contract
// - event 08H mask 08H counts store data TLB misses, speculative included
// - disambiguation reset mask 01H counts each pipeline-clear cycle
// - event 09H mask 02H counts each load disambiguated past unknown store
// - event 0CH mask 01H counts each page walk started
// - event 0CH mask 02H counts every cycle a walk is active
// - event 10H mask 00H counts float compute uops, counter zero only
// - event 11H counts float microcode assists, counter one only
// - event 12H counts multiply operations, counter one only
module pes_selector
	import pes_pkg::*;
#(
	parameter int CW = CNT_WIDTH
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [7:0]    eventCode0,
	input  wire logic [7:0]    unitMask0,
	input  wire logic          countEnable0,
	input  wire logic [7:0]    eventCode1,
	input  wire logic [7:0]    unitMask1,
	input  wire logic          countEnable1,
	input  wire logic          counterClear,
	input  wire logic          data_tlb_store_miss_event,
	input  wire logic          disambigClear,
	input  wire logic          load_store_resolved_event,
	input  wire logic          walkStart,
	input  wire logic          walkActive,
	input  wire logic [1:0]    float_compute_uop_event,
	input  wire logic [1:0]    product_op_event,
	input  wire logic          simdOpValid,
	input  wire logic          simdDenormalIn,
	input  wire logic          simdUnderflowOut,
	input  wire logic          denormal_input_zeroing_flag,
	input  wire logic          underflow_result_flush_flag,
	input  wire logic          x87OpValid,
	input  wire logic          x87NanOrDenormLoad,
	input  wire logic          x87DivByZero,
	input  wire logic          x87UnderflowOut,
	output logic [CW-1:0]      general_counter_zero,
	output logic [CW-1:0]      general_counter_one,
	output logic               selectInvalid0,
	output logic               selectInvalid1
);
	import pes_pkg::*;

	logic          helpEvent;
	logic [CW-1:0] cnt0Reg;
	logic [CW-1:0] cnt0Next;
	logic [CW-1:0] cnt1Reg;
	logic [CW-1:0] cnt1Next;
	logic [1:0]    inc0;
	logic [1:0]    inc1;
	pes_src_t      src0;
	pes_src_t      src1;

	// ****************************************************************
	// assist source, one cycle behind the pipeline flags
	// ****************************************************************
	pes_fp_help uHelp (
		.clk                         (clk),
		.rst_n                       (rst_n),
		.simdOpValid                 (simdOpValid),
		.simdDenormalIn              (simdDenormalIn),
		.simdUnderflowOut            (simdUnderflowOut),
		.denormal_input_zeroing_flag (denormal_input_zeroing_flag),
		.underflow_result_flush_flag (underflow_result_flush_flag),
		.x87OpValid                  (x87OpValid),
		.x87NanOrDenormLoad          (x87NanOrDenormLoad),
		.x87DivByZero                (x87DivByZero),
		.x87UnderflowOut             (x87UnderflowOut),
		.float_microcode_help_event  (helpEvent)
	);

	// ****************************************************************
	// decode and per-source increment
	// ****************************************************************
	// counter-restricted events decode to SRC_NONE on the wrong counter,
	// so a misprogrammed selector simply never counts
	function automatic pes_src_t decodeSel(input logic [7:0] code, input logic [7:0] mask,
		input logic [0:0] which);
		pes_src_t s;
		s = SRC_NONE;
		if (code == EVT_DTLB && mask == UM_STORE_MISS) s = SRC_STORE_MISS;
		if (code == EVT_DISAMBIG && mask == UM_DIS_RESET) s = SRC_DIS_RESET;
		if (code == EVT_DISAMBIG && mask == UM_DIS_SUCCESS) s = SRC_DIS_SUCCESS;
		if (code == EVT_PAGE_WALK && mask == UM_WALK_COUNT) s = SRC_WALK_START;
		if (code == EVT_PAGE_WALK && mask == UM_WALK_CYCLES) s = SRC_WALK_BUSY;
		if (code == EVT_FP_COMP && mask == UM_NONE && which == COUNTER_ZERO) s = SRC_FP_COMP;
		if (code == EVT_FP_HELP && mask == UM_NONE && which == COUNTER_ONE) s = SRC_FP_HELP;
		if (code == EVT_PRODUCT && mask == UM_NONE && which == COUNTER_ONE) s = SRC_PRODUCT;
		return s;
	endfunction : decodeSel

	function automatic logic [1:0] srcInc(input pes_src_t s);
		logic [1:0] v;
		v = 2'h0;
		unique case (s)
			SRC_NONE:        v = 2'h0;
			SRC_STORE_MISS:  v = {1'b0, data_tlb_store_miss_event};
			SRC_DIS_RESET:   v = {1'b0, disambigClear};
			SRC_DIS_SUCCESS: v = {1'b0, load_store_resolved_event};
			SRC_WALK_START:  v = {1'b0, walkStart};
			SRC_WALK_BUSY:   v = {1'b0, walkActive};
			SRC_FP_COMP:     v = float_compute_uop_event;
			SRC_FP_HELP:     v = {1'b0, helpEvent};
			SRC_PRODUCT:     v = product_op_event;
			default:         v = 2'h0;
		endcase
		return v;
	endfunction : srcInc

	always_comb begin
		src0 = decodeSel(eventCode0, unitMask0, COUNTER_ZERO);
		src1 = decodeSel(eventCode1, unitMask1, COUNTER_ONE);
		inc0 = countEnable0 ? srcInc(src0) : 2'h0;
		inc1 = countEnable1 ? srcInc(src1) : 2'h0;
		cnt0Next = counterClear ? '0 : cnt0Reg + CW'(inc0);
		cnt1Next = counterClear ? '0 : cnt1Reg + CW'(inc1);
	end

	// ****************************************************************
	// counters
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt0Reg <= '0;
			cnt1Reg <= '0;
		end else begin
			cnt0Reg <= cnt0Next;
			cnt1Reg <= cnt1Next;
		end
	end

	assign general_counter_zero = cnt0Reg;
	assign general_counter_one  = cnt1Reg;
	assign selectInvalid0       = countEnable0 && (src0 == SRC_NONE);
	assign selectInvalid1       = countEnable1 && (src1 == SRC_NONE);

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_store_miss_count: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_DTLB && unitMask0 == UM_STORE_MISS
		&& data_tlb_store_miss_event |=> general_counter_zero == $past(general_counter_zero) + 1)
		else $error("store miss not counted");
	chk_dis_reset_count: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && !counterClear && eventCode1 == EVT_DISAMBIG && unitMask1 == UM_DIS_RESET
		&& disambigClear |=> general_counter_one == $past(general_counter_one) + 1)
		else $error("disambiguation clear cycle not counted");
	chk_dis_success: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_DISAMBIG && unitMask0 == UM_DIS_SUCCESS
		&& !load_store_resolved_event |=> general_counter_zero == $past(general_counter_zero))
		else $error("success counted without event");
	chk_walk_start: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_PAGE_WALK && unitMask0 == UM_WALK_COUNT
		&& walkStart && !walkActive |=> general_counter_zero == $past(general_counter_zero) + 1)
		else $error("walk start not counted");
	chk_walk_cycles: assert property (@(posedge clk) disable iff (!rst_n)
		(countEnable1 && !counterClear && eventCode1 == EVT_PAGE_WALK && unitMask1 == UM_WALK_CYCLES
		&& walkActive)[*3] |=> general_counter_one == $past(general_counter_one, 3) + 3)
		else $error("walk duration miscounted");
	chk_fp_comp_zero: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && !counterClear && eventCode1 == EVT_FP_COMP
		|=> general_counter_one == $past(general_counter_one))
		else $error("float compute counted on counter one");
	chk_help_one: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_FP_HELP
		|=> general_counter_zero == $past(general_counter_zero))
		else $error("assist counted on counter zero");
	chk_product_one: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && !counterClear && eventCode1 == EVT_PRODUCT && unitMask1 == UM_NONE
		|=> general_counter_one == $past(general_counter_one) + CW'($past(product_op_event)))
		else $error("multiply count wrong");
	chk_disabled_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!countEnable0 && !counterClear |=> $stable(general_counter_zero))
		else $error("disabled counter moved");

	// ****************************************************************
	// quiet, count, restriction and clear checks
	// ****************************************************************
	// a source held low must leave its counter alone, or a stuck decode would pass unseen
	chk_store_miss_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_DTLB && unitMask0 == UM_STORE_MISS
		&& !data_tlb_store_miss_event |=> $stable(general_counter_zero))
		else $error("store miss counted without event");
	chk_dis_reset_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && !counterClear && eventCode1 == EVT_DISAMBIG && unitMask1 == UM_DIS_RESET
		&& !disambigClear |=> $stable(general_counter_one))
		else $error("disambiguation clear counted without event");
	chk_dis_success_count: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_DISAMBIG && unitMask0 == UM_DIS_SUCCESS
		&& load_store_resolved_event |=> general_counter_zero == $past(general_counter_zero) + 1)
		else $error("success not counted");
	chk_walk_start_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_PAGE_WALK && unitMask0 == UM_WALK_COUNT
		&& !walkStart |=> $stable(general_counter_zero))
		else $error("walk counted without start");
	chk_walk_busy_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && !counterClear && eventCode1 == EVT_PAGE_WALK && unitMask1 == UM_WALK_CYCLES
		&& !walkActive |=> $stable(general_counter_one))
		else $error("walk cycle counted while idle");
	chk_fp_comp_count: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_FP_COMP && unitMask0 == UM_NONE
		|=> general_counter_zero == $past(general_counter_zero) + CW'($past(float_compute_uop_event)))
		else $error("float compute count wrong");
	chk_help_count: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && !counterClear && eventCode1 == EVT_FP_HELP && unitMask1 == UM_NONE
		&& helpEvent |=> general_counter_one == $past(general_counter_one) + 1)
		else $error("assist not counted");
	chk_product_zero: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && !counterClear && eventCode0 == EVT_PRODUCT
		|=> $stable(general_counter_zero))
		else $error("multiply counted on counter zero");
	// the flag is the only sign software gets of a restricted event on the wrong counter
	chk_wrong_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable0 && (eventCode0 == EVT_FP_HELP || eventCode0 == EVT_PRODUCT)
		|-> selectInvalid0)
		else $error("restricted event on counter zero not flagged");
	chk_wrong_one_flag: assert property (@(posedge clk) disable iff (!rst_n)
		countEnable1 && eventCode1 == EVT_FP_COMP |-> selectInvalid1)
		else $error("restricted event on counter one not flagged");
	chk_disabled_hold_one: assert property (@(posedge clk) disable iff (!rst_n)
		!countEnable1 && !counterClear |=> $stable(general_counter_one))
		else $error("disabled counter one moved");
	// clear wins over any count landing in the same cycle
	chk_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
		counterClear |=> general_counter_zero == CW'(0) && general_counter_one == CW'(0))
		else $error("clear did not empty counters");
endmodule : pes_selector

// ==== verification/pes_event_source.sv ====
`timescale 1ns/1ps
// ****************************************************************
// pipeline event source model
// ****************************************************************
// pulses are combinational from the request, so a released source reads 0
module pes_event_source
	import pes_pkg::*;
(
	input  wire logic       evOn,
	input  wire pes_src_t   evKind,
	input  wire logic [2:0] evArg,
	output logic            data_tlb_store_miss_event,
	output logic            disambigClear,
	output logic            load_store_resolved_event,
	output logic            walkStart,
	output logic            walkActive,
	output logic [1:0]      float_compute_uop_event,
	output logic [1:0]      product_op_event,
	output logic            simdOpValid,
	output logic            simdDenormalIn,
	output logic            simdUnderflowOut,
	output logic            x87OpValid,
	output logic            x87NanOrDenormLoad,
	output logic            x87DivByZero,
	output logic            x87UnderflowOut
);
	logic help;
	assign help = evOn && evKind == SRC_FP_HELP;
	assign data_tlb_store_miss_event = evOn && evKind == SRC_STORE_MISS;
	assign disambigClear = evOn && evKind == SRC_DIS_RESET;
	assign load_store_resolved_event = evOn && evKind == SRC_DIS_SUCCESS;
	assign walkStart = evOn && evKind == SRC_WALK_START;
	assign walkActive = evOn && evKind == SRC_WALK_BUSY;
	assign float_compute_uop_event = (evOn && evKind == SRC_FP_COMP) ? evArg[1:0] : 2'h0;
	assign product_op_event = (evOn && evKind == SRC_PRODUCT) ? evArg[1:0] : 2'h0;
	// one assist cause per cycle, chosen by evArg
	assign simdOpValid = help && evArg < 3'h2;
	assign simdDenormalIn = help && evArg == 3'h0;
	assign simdUnderflowOut = help && evArg == 3'h1;
	assign x87OpValid = help && evArg >= 3'h2;
	assign x87NanOrDenormLoad = help && evArg == 3'h2;
	assign x87DivByZero = help && evArg == 3'h3;
	assign x87UnderflowOut = help && evArg == 3'h4;
endmodule : pes_event_source

// ==== verification/pes_selector_bench.sv ====
`timescale 1ns/1ps
`define CHECK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t value mismatch", $time); end end
module pes_selector_bench;
	import pes_pkg::*;
	logic clk, rst_n, counterClear, zeroFlag, flushFlag, evOn;
	logic [7:0] eventCode0, unitMask0, eventCode1, unitMask1;
	logic countEnable0, countEnable1, selectInvalid0, selectInvalid1;
	logic storeMiss, disClr, resolved, walkStart, walkActive, simdV, simdDen, simdUnd, x87V, x87Nan, x87Div, x87Und;
	logic [1:0] fpComp, product;
	logic [2:0] evArg;
	pes_src_t evKind;
	logic [CNT_WIDTH-1:0] general_counter_zero, general_counter_one;
	int n_mismatch = 0;
	int check_count = 0;
	pes_event_source SRC (.evOn(evOn), .evKind(evKind), .evArg(evArg), .data_tlb_store_miss_event(storeMiss),
		.disambigClear(disClr), .load_store_resolved_event(resolved), .walkStart(walkStart), .walkActive(walkActive),
		.float_compute_uop_event(fpComp), .product_op_event(product), .simdOpValid(simdV), .simdDenormalIn(simdDen),
		.simdUnderflowOut(simdUnd), .x87OpValid(x87V), .x87NanOrDenormLoad(x87Nan), .x87DivByZero(x87Div),
		.x87UnderflowOut(x87Und));
	pes_selector DUT (.clk(clk), .rst_n(rst_n), .eventCode0(eventCode0), .unitMask0(unitMask0),
		.countEnable0(countEnable0), .eventCode1(eventCode1), .unitMask1(unitMask1), .countEnable1(countEnable1),
		.counterClear(counterClear), .data_tlb_store_miss_event(storeMiss), .disambigClear(disClr),
		.load_store_resolved_event(resolved), .walkStart(walkStart), .walkActive(walkActive),
		.float_compute_uop_event(fpComp), .product_op_event(product), .simdOpValid(simdV), .simdDenormalIn(simdDen),
		.simdUnderflowOut(simdUnd), .denormal_input_zeroing_flag(zeroFlag), .underflow_result_flush_flag(flushFlag),
		.x87OpValid(x87V), .x87NanOrDenormLoad(x87Nan), .x87DivByZero(x87Div), .x87UnderflowOut(x87Und),
		.general_counter_zero(general_counter_zero), .general_counter_one(general_counter_one),
		.selectInvalid0(selectInvalid0), .selectInvalid1(selectInvalid1));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic finish_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	function automatic logic [CNT_WIDTH-1:0] cnt(input logic which);
		return which ? general_counter_one : general_counter_zero;
	endfunction : cnt
	// ****************************************************************
	// select, fire n cycles, settle, compare growth
	// ****************************************************************
	// three idle cycles cover the one-cycle assist lag
	task automatic fire_check(input logic which, input logic [7:0] c, input logic [7:0] m, input pes_src_t k,
		input logic [2:0] a, input int n, input int expAdd);
		logic [CNT_WIDTH-1:0] start;
		if (which) begin
			eventCode1 = c; unitMask1 = m; countEnable1 = 1'b1;
		end else begin
			eventCode0 = c; unitMask0 = m; countEnable0 = 1'b1;
		end
		step(1);
		start = cnt(which);
		evKind = k; evArg = a; evOn = 1'b1;
		step(n);
		evOn = 1'b0;
		step(3);
		`CHECK(cnt(which) - start, CNT_WIDTH'(expAdd))
	endtask : fire_check
	task automatic t_sources;
		fire_check(0, EVT_DTLB, UM_STORE_MISS, SRC_STORE_MISS, 3'h0, 3, 3);
		fire_check(1, EVT_DISAMBIG, UM_DIS_RESET, SRC_DIS_RESET, 3'h0, 4, 4);
		fire_check(0, EVT_DISAMBIG, UM_DIS_SUCCESS, SRC_DIS_SUCCESS, 3'h0, 2, 2);
		fire_check(0, EVT_PAGE_WALK, UM_WALK_COUNT, SRC_WALK_START, 3'h0, 1, 1);
		fire_check(1, EVT_PAGE_WALK, UM_WALK_CYCLES, SRC_WALK_BUSY, 3'h0, 7, 7);
		fire_check(0, EVT_FP_COMP, UM_NONE, SRC_FP_COMP, 3'h3, 2, 6);
		fire_check(1, EVT_PRODUCT, UM_NONE, SRC_PRODUCT, 3'h2, 3, 6);
		fire_check(0, EVT_DTLB, UM_STORE_MISS, SRC_WALK_START, 3'h0, 2, 0);
		fire_check(0, EVT_PAGE_WALK, UM_WALK_CYCLES, SRC_WALK_START, 3'h0, 2, 0);
	endtask : t_sources
	task automatic t_assist;
		for (int i = 0; i < 5; i++)
			fire_check(1, EVT_FP_HELP, UM_NONE, SRC_FP_HELP, 3'(i), 2, 2);
		zeroFlag = 1'b1;
		fire_check(1, EVT_FP_HELP, UM_NONE, SRC_FP_HELP, 3'h0, 2, 0);
		zeroFlag = 1'b0;
		flushFlag = 1'b1;
		fire_check(1, EVT_FP_HELP, UM_NONE, SRC_FP_HELP, 3'h1, 2, 0);
		fire_check(1, EVT_FP_HELP, UM_NONE, SRC_FP_HELP, 3'h4, 2, 2);
		flushFlag = 1'b0;
	endtask : t_assist
	task automatic t_refuse;
		fire_check(1, EVT_FP_COMP, UM_NONE, SRC_FP_COMP, 3'h1, 2, 0);
		`CHECK(selectInvalid1, 1'b1)
		fire_check(0, EVT_PRODUCT, UM_NONE, SRC_PRODUCT, 3'h1, 2, 0);
		`CHECK(selectInvalid0, 1'b1)
		fire_check(0, EVT_FP_HELP, UM_NONE, SRC_FP_HELP, 3'h2, 2, 0);
		`CHECK(selectInvalid0, 1'b1)
		fire_check(0, EVT_DTLB, UM_STORE_MISS, SRC_STORE_MISS, 3'h0, 1, 1);
		`CHECK(selectInvalid0, 1'b0)
		counterClear = 1'b1;
		step(1);
		counterClear = 1'b0;
		`CHECK(general_counter_zero | general_counter_one, CNT_WIDTH'(0))
	endtask : t_refuse
	initial begin
		rst_n = 1'b0; counterClear = 1'b0; zeroFlag = 1'b0; flushFlag = 1'b0;
		evOn = 1'b0; evKind = SRC_NONE; evArg = 3'h0;
		eventCode0 = 8'h00; unitMask0 = 8'h00; countEnable0 = 1'b0;
		eventCode1 = 8'h00; unitMask1 = 8'h00; countEnable1 = 1'b0;
		step(3);
		rst_n = 1'b1;
		t_sources;
		t_assist;
		t_refuse;
		finish_test;
	end
	// roughly 140 cycles expected; generous margin
	initial begin
		#20000;
		n_mismatch++;
		finish_test;
	end
endmodule : pes_selector_bench
